// >>> core/sld_device.sv
// Driver end: shift register, storage register and gated sink outputs.
`timescale 1ns/1ps
module sld_device (
    sld_link_if.dev             link,      // Link from host or prior driver.
    input  wire logic           rstn_i,    // Asynchronous reset, active low.
    output logic [sld_pkg::CHANNELS-1:0] led_o, // Sink on, one per channel.
    output logic                ser_out_o  // Serial data to next driver.
);
    import sld_pkg::*;

    // State updated on the rising edge of the shift clock.
    typedef struct packed {
        logic         sample;
        logic         strobe;
        logic         gate_meta;
        logic         gate_sync;
        sld_word_type led;
    } sld_rise_type;

    // State updated on the falling edge of the shift clock.
    typedef struct packed {
        sld_word_type shift;
        sld_word_type storage;
        logic         ser_out;
    } sld_fall_type;

    sld_rise_type rise_reg;
    sld_rise_type rise_next;
    sld_fall_type fall_reg;
    sld_fall_type fall_next;

    // Rising edge: capture data and strobe, resynchronise the gate.
    // The gate comes from the host's own clock, so it is treated as
    // asynchronous; the output therefore lags the PWM by three rising edges.
    always_comb begin
        rise_next           = rise_reg;
        rise_next.sample    = link.sdata;
        rise_next.strobe    = link.storage_strobe;
        rise_next.gate_meta = link.output_gate;
        rise_next.gate_sync = rise_reg.gate_meta;
        if (rise_reg.gate_sync) begin
            rise_next.led = fall_reg.storage;
        end else begin
            rise_next.led = '0;
        end
    end

    // Falling edge: shift one place and copy into storage if strobed.
    // The copy takes the contents from before this edge's shift.
    always_comb begin
        fall_next       = fall_reg;
        fall_next.shift = {fall_reg.shift[CHANNELS-2:0],
                           rise_reg.sample};
        // The onward bit is the new MSB after this shift, so the next
        // driver sees it one edge ahead of its own capture, with no
        // extra bit of delay per driver in the cascade.
        fall_next.ser_out = fall_reg.shift[CHANNELS-2];
        if (rise_reg.strobe) begin
            fall_next.storage = fall_reg.shift;
        end else begin
            fall_next.storage = fall_reg.storage;
        end
    end

    // Rising-edge register.
    always_ff @(posedge link.sclk or negedge rstn_i) begin
        if (!rstn_i) begin
            rise_reg <= '0;
        end else begin
            rise_reg <= rise_next;
        end
    end

    // Falling-edge register.
    always_ff @(negedge link.sclk or negedge rstn_i) begin
        if (!rstn_i) begin
            fall_reg <= '0;
        end else begin
            fall_reg <= fall_next;
        end
    end

    // Outputs come straight from the registers.
    assign led_o     = rise_reg.led;
    assign ser_out_o = fall_reg.ser_out;
endmodule // sld_device

// >>> core/sld_host.sv
// Host end: word FIFO, shift clock divider, framing and PWM gate.
// Summary of operation
// - Shift register holds one bit per channel.
// - Falling clock edge shifts, presents bit onward.
// - Serial output feeds the next driver's input.
// - Host keeps shift clock at most 30 MHz.
// - Host changes data only at falling edges.
// - Host shifts whole chain before raising strobe.
// - Strobe high copies shift register into storage.
// - Strobe low keeps storage and outputs unchanged.
// - Sinks follow stored bits only while gate allows.
// - Host sets brightness by PWM on the gate.
// - Host waits adjustable delay after each strobe.
`timescale 1ns/1ps
module sld_fifo #(
    parameter int WIDTH = 16,
    parameter int DEPTH = 4
) (
    input  wire logic                       sys_clk_i,   // System clock.
    input  wire logic                       rstn_i,      // Reset, active low.
    input  wire logic [WIDTH-1:0]           in_data_i,   // Word to store.
    input  wire logic                       in_valid_i,  // Word offered.
    output logic                            in_ready_o,  // Room for a word.
    output logic [WIDTH-1:0]                out_data_o,  // Oldest word.
    output logic                            out_valid_o, // Word available.
    input  wire logic                       out_ready_i, // Word taken.
    output logic [$clog2(DEPTH):0]          level_o      // Words held.
);
    localparam int PTR_W = $clog2(DEPTH);
    localparam int LVL_W = PTR_W + 1;
    localparam logic [LVL_W-1:0] FULL_LVL = LVL_W'(DEPTH);
    localparam logic [PTR_W-1:0] PTR_LAST = PTR_W'(DEPTH - 1);

    typedef struct packed {
        logic [DEPTH-1:0][WIDTH-1:0] mem;
        logic [PTR_W-1:0]            wr_ptr;
        logic [PTR_W-1:0]            rd_ptr;
        logic [LVL_W-1:0]            level;
        logic                        ready;
        logic                        valid;
    } fifo_state_type;

    fifo_state_type fifo_reg;
    fifo_state_type fifo_next;
    logic           push;
    logic           pop;

    // Wrapping pointer increment, used by both pointers.
    function automatic logic [PTR_W-1:0] ptr_inc(input logic [PTR_W-1:0] p);
        ptr_inc = (p == PTR_LAST) ? '0 : p + 1'b1;
    endfunction

    assign push = in_valid_i && fifo_reg.ready;
    assign pop  = out_ready_i && fifo_reg.valid;

    // Ready and valid are kept as flags so both ports come from flops.
    always_comb begin
        fifo_next = fifo_reg;
        if (push) begin
            fifo_next.mem[fifo_reg.wr_ptr] = in_data_i;
            fifo_next.wr_ptr = ptr_inc(fifo_reg.wr_ptr);
        end
        if (pop) begin
            fifo_next.rd_ptr = ptr_inc(fifo_reg.rd_ptr);
        end
        if (push && !pop) begin
            fifo_next.level = fifo_reg.level + 1'b1;
        end else if (pop && !push) begin
            fifo_next.level = fifo_reg.level - 1'b1;
        end
        fifo_next.ready = (fifo_next.level != FULL_LVL);
        fifo_next.valid = (fifo_next.level != '0);
    end

    // State register.
    always_ff @(posedge sys_clk_i or negedge rstn_i) begin
        if (!rstn_i) begin
            fifo_reg <= '0;
        end else begin
            fifo_reg <= fifo_next;
        end
    end

    assign in_ready_o  = fifo_reg.ready;
    assign out_valid_o = fifo_reg.valid;
    assign out_data_o  = fifo_reg.mem[fifo_reg.rd_ptr];
    assign level_o     = fifo_reg.level;
endmodule // sld_fifo

module sld_host (
    input  wire logic                        sys_clk_i,    // System clock.
    input  wire logic                        rstn_i,       // Reset, low.
    input  wire logic [sld_pkg::CHANNELS-1:0] word_i,      // Driver word.
    input  wire logic                        word_valid_i, // Word offered.
    output logic                             word_ready_o, // Word accepted.
    input  wire logic [sld_pkg::DUTY_W-1:0]  duty_i,       // Gate duty.
    input  wire logic [sld_pkg::DELAY_W-1:0] delay_i,      // Post-strobe wait.
    output logic                             busy_o,       // Frame running.
    sld_link_if.host                         link          // Link to chain.
);
    import sld_pkg::*;

    typedef struct packed {
        sld_host_state_type state;
        logic [DIV_W-1:0]   div_cnt;
        logic               sclk;
        logic               sdata;
        logic               strobe;
        logic               gate;
        logic [DUTY_W-1:0]  pwm_cnt;
        sld_word_type       shift;
        logic [BIT_W-1:0]   bit_cnt;
        logic [WORD_W-1:0]  word_cnt;
        logic [DELAY_W-1:0] wait_cnt;
        logic               busy;
    } sld_host_reg_type;

    sld_host_reg_type host_reg;
    sld_host_reg_type host_next;
    sld_word_type     fifo_data;
    logic [LEVEL_W-1:0] fifo_level;
    logic             fifo_pop;
    logic             fall;

    // The FIFO stalls the user only when it holds FIFO_DEPTH words.
    sld_fifo #(
        .WIDTH (CHANNELS),
        .DEPTH (FIFO_DEPTH)
    ) u_fifo (
        .sys_clk_i   (sys_clk_i),
        .rstn_i      (rstn_i),
        .in_data_i   (word_i),
        .in_valid_i  (word_valid_i),
        .in_ready_o  (word_ready_o),
        .out_data_o  (fifo_data),
        .out_valid_o (),
        .out_ready_i (fifo_pop),
        .level_o     (fifo_level)
    );

    // Divider makes the shift clock; data and strobe changes ride its fall, the gate does not.
    // A frame starts only when the whole chain is buffered, so a word
    // never runs short mid-frame while the clock keeps running.
    always_comb begin
        host_next = host_reg;
        fifo_pop  = 1'b0;
        fall      = 1'b0;
        if (host_reg.div_cnt == DIV_LAST) begin
            host_next.div_cnt = '0;
            host_next.sclk    = ~host_reg.sclk;
            fall              = host_reg.sclk;
        end else begin
            host_next.div_cnt = host_reg.div_cnt + 1'b1;
        end
        host_next.pwm_cnt = host_reg.pwm_cnt + 1'b1;
        host_next.gate    = (host_reg.pwm_cnt < duty_i);
        case (host_reg.state)
            SLD_IDLE: begin
                if (fall && fifo_level >= CHAIN_LEVEL) begin
                    fifo_pop           = 1'b1;
                    host_next.sdata    = fifo_data[CHANNELS-1];
                    host_next.shift    = {fifo_data[CHANNELS-2:0], 1'b0};
                    host_next.bit_cnt  = BIT_FIRST;
                    host_next.word_cnt = WORD_FIRST;
                    host_next.busy     = 1'b1;
                    host_next.state    = SLD_SHIFT;
                end
            end
            SLD_SHIFT: begin
                if (fall) begin
                    if (host_reg.bit_cnt != BIT_FULL) begin
                        host_next.sdata = host_reg.shift[CHANNELS-1];
                        host_next.shift = {host_reg.shift[CHANNELS-2:0],
                                           1'b0};
                        host_next.bit_cnt = host_reg.bit_cnt + 1'b1;
                    end else if (host_reg.word_cnt != WORD_FULL) begin
                        fifo_pop           = 1'b1;
                        host_next.sdata    = fifo_data[CHANNELS-1];
                        host_next.shift    = {fifo_data[CHANNELS-2:0],
                                              1'b0};
                        host_next.bit_cnt  = BIT_FIRST;
                        host_next.word_cnt = host_reg.word_cnt + 1'b1;
                    end else begin
                        host_next.strobe = 1'b1;
                        host_next.state  = SLD_STROBE;
                    end
                end
            end
            SLD_STROBE: begin
                if (fall) begin
                    host_next.strobe   = 1'b0;
                    host_next.wait_cnt = delay_i;
                    host_next.state    = SLD_WAIT;
                end
            end
            SLD_WAIT: begin
                if (fall) begin
                    if (host_reg.wait_cnt == '0) begin
                        host_next.busy  = 1'b0;
                        host_next.state = SLD_IDLE;
                    end else begin
                        host_next.wait_cnt = host_reg.wait_cnt - 1'b1;
                    end
                end
            end
            default: begin
                host_next.state = SLD_IDLE;
            end
        endcase
    end

    // State register.
    always_ff @(posedge sys_clk_i or negedge rstn_i) begin
        if (!rstn_i) begin
            host_reg <= '0;
        end else begin
            host_reg <= host_next;
        end
    end

    assign busy_o              = host_reg.busy;
    assign link.sclk           = host_reg.sclk;
    assign link.sdata          = host_reg.sdata;
    assign link.storage_strobe = host_reg.strobe;
    assign link.output_gate    = host_reg.gate;
endmodule // sld_host

// >>> inc/sld_link_if.sv
// Link from the host controller, or a prior driver, to a driver of the cascade.
`timescale 1ns/1ps
interface sld_link_if;
    logic sclk;           // Shift clock, made by the host.
    logic sdata;          // Serial data, changed at falling edges.
    logic storage_strobe; // High copies shift register into storage.
    logic output_gate;    // High lets the stored bits drive the sinks.

    modport host (
        output sclk,
        output sdata,
        output storage_strobe,
        output output_gate
    );
    modport dev (
        input  sclk,
        input  sdata,
        input  storage_strobe,
        input  output_gate
    );
endinterface

// >>> inc/sld_pkg.sv
// Shared constants and types for the serial LED driver link.
package sld_pkg;
    // Channel count of one driver (one bit per current sink).
    localparam int CHANNELS   = 16;
    // Number of drivers in the cascade fed by one host.
    localparam int CHAIN_LEN  = 2;
    localparam int FIFO_DEPTH = 4;
    // Fastest shift clock the drivers accept, and the host's own rate.
    localparam int SCLK_MAX_HZ = 30_000_000;
    localparam int SYS_HZ      = 10_000_000;
    // Half period of the shift clock in system cycles, rounded up.
    localparam int SCLK_HALF_N = (SYS_HZ + 2 * SCLK_MAX_HZ - 1)
                                 / (2 * SCLK_MAX_HZ);
    localparam int SCLK_HALF   = (SCLK_HALF_N < 1) ? 1 : SCLK_HALF_N;

    localparam int DIV_W   = 4;
    localparam int DUTY_W  = 8;
    localparam int DELAY_W = 16;
    localparam int BIT_W   = $clog2(CHANNELS) + 1;
    localparam int WORD_W  = $clog2(CHAIN_LEN) + 1;
    localparam int LEVEL_W = $clog2(FIFO_DEPTH) + 1;

    localparam logic [DIV_W-1:0]   DIV_LAST    = DIV_W'(SCLK_HALF - 1);
    localparam logic [BIT_W-1:0]   BIT_FULL    = BIT_W'(CHANNELS);
    localparam logic [BIT_W-1:0]   BIT_FIRST   = 5'h01;
    localparam logic [WORD_W-1:0]  WORD_FULL   = WORD_W'(CHAIN_LEN);
    localparam logic [WORD_W-1:0]  WORD_FIRST  = 2'h1;
    localparam logic [LEVEL_W-1:0] CHAIN_LEVEL = LEVEL_W'(CHAIN_LEN);

    typedef logic [CHANNELS-1:0] sld_word_type;

    typedef enum logic [1:0] {
        SLD_IDLE,
        SLD_SHIFT,
        SLD_STROBE,
        SLD_WAIT
    } sld_host_state_type;
endpackage

// >>> testbench/sld_link_properties.sv
// Concurrent checks on the host-to-driver link.
`timescale 1ns/1ps
module sld_link_properties (
    input wire logic sys_clk_i,      // Host clock.
    input wire logic rstn_i,         // Reset, active low.
    input wire logic sclk,           // Shift clock.
    input wire logic sdata,          // Serial data.
    input wire logic storage_strobe, // Storage copy strobe.
    input wire logic output_gate     // Sink enable.
);
    default clocking cb @(posedge sys_clk_i); endclocking
    default disable iff (!rstn_i);
    logic [7:0] falls_reg;
    logic       sclk_reg;
    logic       strobe_reg;

    // Falls since the last strobe; saturates so long waits stay harmless.
    always_ff @(posedge sys_clk_i or negedge rstn_i) begin
        if (!rstn_i) begin
            falls_reg  <= 8'h00;
            sclk_reg   <= 1'b0;
            strobe_reg <= 1'b0;
        end else begin
            sclk_reg   <= sclk;
            strobe_reg <= storage_strobe;
            if (storage_strobe && !strobe_reg) begin
                falls_reg <= 8'h00;
            end else if (sclk_reg && !sclk && falls_reg != 8'hff) begin
                falls_reg <= falls_reg + 8'h01;
            end
        end
    end

    AST_SCLK_HIGH: assert property (sclk |=> !sclk)
        else $error("shift clock high for more than one cycle");
    AST_SCLK_LOW: assert property (!sclk |=> sclk)
        else $error("shift clock low for more than one cycle");
    AST_SDATA_FALL: assert property ($changed(sdata) |-> $fell(sclk))
        else $error("serial data changed away from a clock fall");
    AST_SDATA_RISE: assert property ($rose(sclk) |-> $stable(sdata))
        else $error("serial data moved at a clock rise");
    AST_STROBE_WIDTH: assert property ($rose(storage_strobe) |->
        $fell(sclk) ##1 storage_strobe ##1 $fell(storage_strobe))
        else $error("strobe not one shift period wide");
    AST_STROBE_FRAME: assert property (
        $rose(storage_strobe) |-> falls_reg >= 8'h20)
        else $error("strobe before a whole chain was shifted");
    AST_STROBE_GAP: assert property (
        $fell(storage_strobe) |-> !storage_strobe [*8])
        else $error("strobe repeated without a wait");
    AST_GATE_PWM: assert property (
        $rose(output_gate) |-> ##[1:256] !output_gate)
        else $error("gate high beyond one PWM period");
endmodule // sld_link_properties

// >>> testbench/test_serial_led_driver_latch.sv
// Self-checking bench: host with FIFO feeding a two-driver cascade.
`timescale 1ns/1ps
module test_serial_led_driver_latch;
    import sld_pkg::*;
    logic               sys_clk_i = 1'b0;
    logic               rstn_i = 1'b0;
    sld_word_type       word_i = '0;
    logic               word_valid_i = 1'b0;
    logic               word_ready_o;
    logic [DUTY_W-1:0]  duty_i = 8'hff;
    logic [DELAY_W-1:0] delay_i = 16'h0004;
    logic               busy_o;
    sld_word_type       led0;
    sld_word_type       led1;
    logic               ser0;
    sld_word_type       last_far = '0;
    sld_word_type       last_near = '0;
    sld_word_type       exp_q [$];
    int                 errors = 0;
    int                 compares = 0;

    sld_link_if link0 ();
    sld_link_if link1 ();
    // The second driver shares control lines and takes the first's output.
    assign link1.sclk = link0.sclk;
    assign link1.storage_strobe = link0.storage_strobe;
    assign link1.output_gate = link0.output_gate;
    assign link1.sdata = ser0;

    sld_host i_sld_host (.sys_clk_i(sys_clk_i), .rstn_i(rstn_i),
        .word_i(word_i), .word_valid_i(word_valid_i),
        .word_ready_o(word_ready_o), .duty_i(duty_i), .delay_i(delay_i),
        .busy_o(busy_o), .link(link0.host));
    sld_device i_sld_device_0 (.link(link0.dev), .rstn_i(rstn_i),
        .led_o(led0), .ser_out_o(ser0));
    sld_device i_sld_device_1 (.link(link1.dev), .rstn_i(rstn_i),
        .led_o(led1), .ser_out_o());
    sld_link_properties i_sld_link_properties (.sys_clk_i(sys_clk_i),
        .rstn_i(rstn_i), .sclk(link0.sclk), .sdata(link0.sdata),
        .storage_strobe(link0.storage_strobe),
        .output_gate(link0.output_gate));

    // System clock, 100 ns period.
    always #50 sys_clk_i = ~sys_clk_i;

    // Prints the counts and the verdict, then stops.
    task automatic end_sim();
        $display("compares %0d errors %0d", compares, errors);
        if (errors == 0 && compares > 0) begin
            $display("SIMULATION PASSED");
        end else begin
            $display("SIMULATION FAILED");
        end
        $finish;
    endtask

    task automatic check_word(input string what, input sld_word_type exp,
                              input sld_word_type got);
        compares++;
        if (got !== exp) begin
            errors++;
            $display("unexpected %s: expected %h, seen %h", what, exp, got);
        end
    endtask

    task automatic check_int(input string what, input int exp, input int got);
        compares++;
        if (got != exp) begin
            errors++;
            $display("unexpected %s: expected %0d, seen %0d", what, exp, got);
        end
    endtask

    // Bounded wait for busy to reach a level.
    task automatic wait_busy(input logic lvl);
        int n;
        n = 0;
        while (busy_o !== lvl) begin
            @(negedge sys_clk_i);
            n++;
            if (n > 3000) begin
                errors++;
                $display("unexpected busy: expected %b, seen %b", lvl, busy_o);
                end_sim();
            end
        end
    endtask

    // Offers a word for one cycle; valid stays up for the caller to drop.
    task automatic push(input sld_word_type w, output bit ok);
        word_i = w;
        word_valid_i = 1'b1;
        ok = (word_ready_o === 1'b1);
        @(negedge sys_clk_i);
        if (ok) exp_q.push_back(w);
    endtask

    // A one-cycle gate dip at full duty may blank the sinks briefly.
    task automatic check_leds(input sld_word_type far,
                              input sld_word_type near);
        int n;
        n = 0;
        while ((led1 !== far || led0 !== near) && n < 8) begin
            @(negedge sys_clk_i);
            n++;
        end
        check_word("far driver sinks", far, led1);
        check_word("near driver sinks", near, led0);
    endtask

    // Follows one frame: storage holds while shifting, then shows the pair.
    task automatic frame(output int len);
        realtime t0;
        wait_busy(1'b1);
        t0 = $realtime;
        repeat (30) @(negedge sys_clk_i);
        check_leds(last_far, last_near);
        wait_busy(1'b0);
        len = int'(($realtime - t0) / 100.0);
        last_far = exp_q.pop_front();
        last_near = exp_q.pop_front();
        check_leds(last_far, last_near);
    endtask

    initial begin
        int len_a;
        int len_b;
        int highs;
        int n_ok;
        bit ok;
        logic [DUTY_W-1:0] duty_tab [5] =
            '{8'h01, 8'h80, 8'hff, 8'h00, 8'h00};
        void'($urandom(32'hf441867a));
        repeat (2) @(negedge sys_clk_i);
        rstn_i = 1'b1;
        repeat (2) @(negedge sys_clk_i);
        // Two lone frames; only the post-strobe wait differs.
        for (int k = 0; k < 2; k++) begin
            delay_i = (k == 0) ? 16'h0004 : 16'h0010;
            push(CHANNELS'($urandom), ok);
            push(CHANNELS'($urandom), ok);
            word_valid_i = 1'b0;
            if (k == 0) frame(len_a);
            else frame(len_b);
        end
        check_int("wait length", 2 * (16'h0010 - 16'h0004),
                  len_b - len_a);
        // Gate duty over one PWM period, ending with the sinks blanked.
        duty_tab[3] = DUTY_W'($urandom_range(254, 2));
        foreach (duty_tab[k]) begin
            duty_i = duty_tab[k];
            highs = 0;
            repeat (256) begin
                @(negedge sys_clk_i);
                highs += int'(link0.output_gate === 1'b1);
            end
            check_int("gate duty", int'(duty_tab[k]), highs);
        end
        check_leds('0, '0);
        duty_i = 8'hff;
        repeat (8) @(negedge sys_clk_i);
        check_leds(last_far, last_near);
        // Fill the FIFO behind a long wait until it refuses, then drain.
        delay_i = 16'h00c8;
        n_ok = 0;
        for (int k = 0; k < 8; k++) begin
            push(CHANNELS'($urandom), ok);
            n_ok += int'(ok);
        end
        word_valid_i = 1'b0;
        check_int("fifo refused a word", 1, int'(n_ok < 8));
        repeat (n_ok / 2) frame(len_a);
        // Random words and short waits, including none at all.
        for (int k = 0; k < 4; k++) begin
            delay_i = DELAY_W'($urandom_range(7, 0));
            push(CHANNELS'($urandom), ok);
            push(CHANNELS'($urandom), ok);
            word_valid_i = 1'b0;
            if (exp_q.size() >= 2) frame(len_a);
        end
        end_sim();
    end
endmodule // test_serial_led_driver_latch
